//--- hdl/dio_pkg.sv
// Constants, register map and shared types of the digital I/O conditioning block.
// Assumes one 250 MHz clock and a simple strobe-based register port.
package dio_pkg;

    // Port counts.
    localparam int DIO_NUM_IN  = 5;
    localparam int DIO_NUM_OUT = 2;
    localparam int DIO_NUM_AUX = 7;

    // Register byte offsets.
    localparam logic [7:0] DIO_OFS_SF_EN     = 8'h00;
    localparam logic [7:0] DIO_OFS_IN_INV    = 8'h04;
    localparam logic [7:0] DIO_OFS_FORCE_EN  = 8'h08;
    localparam logic [7:0] DIO_OFS_FORCE_VAL = 8'h0C;
    localparam logic [7:0] DIO_OFS_RAW       = 8'h10;
    localparam logic [7:0] DIO_OFS_SUMMARY   = 8'h14;
    localparam logic [7:0] DIO_OFS_IN_ROUTE  = 8'h18;
    localparam logic [7:0] DIO_OFS_OUT_CTRL  = 8'h20;
    localparam logic [7:0] DIO_OFS_OUT_UNUSE = 8'h24;
    localparam logic [7:0] DIO_OFS_OUT_INV   = 8'h28;
    localparam logic [7:0] DIO_OFS_MAN_EN    = 8'h2C;
    localparam logic [7:0] DIO_OFS_MAN_VAL   = 8'h30;
    localparam logic [7:0] DIO_OFS_APPLIED   = 8'h34;
    localparam logic [7:0] DIO_OFS_OUT_ROUTE = 8'h38;
    localparam logic [7:0] DIO_OFS_LED       = 8'h3C;
    localparam logic [7:0] DIO_OFS_TABLE     = 8'h80;

    // Field positions.
    localparam int DIO_LVL_BASE      = 16;
    localparam int DIO_BIT_INTERLOCK = 3;
    localparam int DIO_BIT_BRAKE     = 0;
    localparam int DIO_BIT_GREEN     = 0;
    localparam int DIO_BIT_RED       = 1;
    localparam int DIO_SRC_INV_BIT   = 7;

    // Reset values.
    localparam logic [31:0] DIO_RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  DIO_RST_LED  = 2'h3;

    // Routing source codes.
    localparam logic [6:0] DIO_SRC_PHYS_FIRST = 7'h01;
    localparam logic [6:0] DIO_SRC_PHYS_LAST  = 7'h10;
    localparam logic [6:0] DIO_SRC_AUX_FIRST  = 7'h41;
    localparam logic [6:0] DIO_SRC_AUX_LAST   = 7'h47;
    localparam logic [7:0] DIO_SRC_ZERO       = 8'h00;
    localparam logic [7:0] DIO_SRC_ONE        = 8'h80;

    // Timing.
    localparam int DIO_CLK_MHZ    = 250;
    localparam int DIO_SAMPLE_US  = 1000;
    localparam int DIO_SAMPLE_CYC = DIO_SAMPLE_US * DIO_CLK_MHZ;
    localparam int DIO_BLINK_MS   = 250;
    localparam int DIO_BLINK_TICK = DIO_BLINK_MS * 1000 / DIO_SAMPLE_US;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } dio_bus_req_t;

    typedef enum logic {
        DIO_MODE_DIRECT = 1'b0,
        DIO_MODE_ROUTED = 1'b1
    } dio_mode_t;

endpackage

//--- hdl/dio_io_cond.sv
// Digital input/output conditioning with input routing, brake and LED control.
// Assumes pins are asynchronous to ref_clk_in and the register master obeys strobe rules.
// Notes on behaviour
// RL1 - Inputs are sampled once per millisecond; shorter pulses may be missed.
// RL2 - Enable mask bits 0..3: negative limit, positive limit, home, interlock.
// RL3 - Enable mask gates only special bits, never the level bits 16..31.
// RL4 - Inversion bit n-1 selects normally open or normally closed for input n.
// RL5 - A force-enable bit replaces the measured level with the force value.
// RL6 - Raw word shows sampled levels before inversion, forcing or routing.
// RL7 - Processed level of input n sits at bit 15+n; low bit is special.
// RL8 - Inputs 1..4 own a special bit and a level bit; input 5 and the outputs own only a level bit.
// RL9 - Routing enable switches routing on and disables the four input masks.
// RL10 - Enabling routing preloads the table so behaviour stays unchanged.
// RL11 - Table entry n drives summary bit n.
// RL12 - Codes: 0 zero, 1..16 inputs, 41..47 Hall, encoder, USB power.
// RL13 - Code bit 7 inverts the source; 80 gives constant one.
// RL14 - Interlock enabled and summary bit 3 low raises the fault state.
// RL15 - Software enables interlock with mask bit 3 and routes its source.
// RL16 - Output n follows control word bit 15+n; low bits are special.
// RL17 - Control word bit 0 drives the motor brake.
// RL18 - Output inversion bit selects whether a one drives high or low.
// RL19 - Manual-enable bit drives output, brake too, from the manual value.
// RL20 - A readable word shows the pattern actually applied to outputs.
// RL21 - Output routing enable switches routing on; unused entry does nothing.
// RL22 - With output routing on, inversion and manual entries have no function.
// RL23 - LED bits enable green (normal) and red (error) blinking; zero keeps off.
// RL24 - A millisecond strobe updates the input summary and applied outputs.
`timescale 1ns/1ps

module dio_io_cond
    import dio_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = DIO_SAMPLE_CYC,
    parameter int unsigned BLINK_TICKS   = DIO_BLINK_TICK
) (
    // Clock and reset.
    input  wire logic                   ref_clk_in,
    input  wire logic                   reset_in,
    // Register port.
    input  wire dio_bus_req_t           bus_req_in,
    output logic [31:0]                 bus_rdata_out,
    // Sensor and switch pins.
    input  wire logic [DIO_NUM_IN-1:0]  in_pin_in,
    input  wire logic [2:0]             hall_in,
    input  wire logic [2:0]             enc_in,
    input  wire logic                   usb_pwr_in,
    // Open-drain outputs, brake and status.
    output logic [DIO_NUM_OUT-1:0]      out_pin_out,
    output logic [DIO_NUM_OUT-1:0]      out_pin_oe_out,
    output logic                        brake_out,
    output logic                        interlock_fault_out,
    output logic                        led_green_out,
    output logic                        led_red_out
);

    localparam int NSRC = DIO_NUM_IN + DIO_NUM_AUX;
    localparam int CW   = $clog2(SAMPLE_CYCLES + 1);
    localparam int BW   = $clog2(BLINK_TICKS + 1);

    logic [NSRC-1:0]   pins_w;
    logic [NSRC-1:0]   s1_r;
    logic [NSRC-1:0]   s2_r;
    logic [NSRC-1:0]   s3_r;
    logic [NSRC-1:0]   stable_r;
    logic [CW-1:0]     cnt_r;
    logic              tick_r;
    logic [BW-1:0]     blink_cnt_r;
    logic              blink_r;
    logic [31:0]       sf_en_r;
    logic [31:0]       in_inv_r;
    logic [31:0]       force_en_r;
    logic [31:0]       force_val_r;
    logic [31:0]       raw_r;
    logic [31:0]       summary_r;
    logic [31:0]       summary_nxt;
    logic [31:0]       direct_w;
    logic [31:0]       routed_w;
    logic [DIO_NUM_IN-1:0] proc_w;
    dio_mode_t         mode_r;
    logic [7:0]        route_tbl_r [32];
    logic [31:0]       out_ctrl_r;
    logic [31:0]       out_inv_r;
    logic [31:0]       man_en_r;
    logic [31:0]       man_val_r;
    logic              out_route_r;
    logic [1:0]        led_r;
    logic [31:0]       applied_r;
    logic [31:0]       applied_nxt;
    logic              wr_w;
    logic [7:0]        addr_w;
    logic [31:0]       wd_w;
    logic              route_on_w;

    assign pins_w = {usb_pwr_in, enc_in, hall_in, in_pin_in};
    assign wr_w   = bus_req_in.wr;
    assign addr_w = bus_req_in.addr;
    assign wd_w   = bus_req_in.wdata;
    assign route_on_w = wr_w && (addr_w == DIO_OFS_IN_ROUTE) && wd_w[0]
                        && (mode_r == DIO_MODE_DIRECT);

    // Three-stage synchroniser; a level is accepted once stages two and three agree.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            stable_r <= '0;
        end else begin
            s1_r     <= pins_w;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= (stable_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
        end
    end

    // Millisecond sampling strobe.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r == CW'(SAMPLE_CYCLES - 1)) begin
            cnt_r  <= '0;
            tick_r <= 1'b1; // [RL1] [RL24]
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // Blink phase for the status LEDs, stepped by the millisecond strobe.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (tick_r) begin
            if (blink_cnt_r == BW'(BLINK_TICKS - 1)) begin
                blink_cnt_r <= '0;
                blink_r     <= ~blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 1'b1;
            end
        end
    end

    // Table code that reproduces the direct-mode behaviour of summary bit b.
    function automatic logic [7:0] dflt_code(input int b, input logic [31:0] en,
                                             input logic [31:0] inv,
                                             input logic [31:0] fen,
                                             input logic [31:0] fval);
        int k;
        k = (b < DIO_LVL_BASE) ? b : b - DIO_LVL_BASE;
        if (k >= DIO_NUM_IN || (b < DIO_LVL_BASE && (b > DIO_BIT_INTERLOCK || !en[k]))) begin
            return DIO_SRC_ZERO;
        end
        if (fen[k]) begin
            return fval[k] ? DIO_SRC_ONE : DIO_SRC_ZERO;
        end
        return {inv[k], 7'(k + 1)};
    endfunction

    // Source selection of one routing entry.
    function automatic logic route_bit(input logic [7:0] code, input logic [15:0] phys,
                                       input logic [DIO_NUM_AUX-1:0] aux);
        logic v;
        v = 1'b0;
        if (code[6:0] >= DIO_SRC_PHYS_FIRST && code[6:0] <= DIO_SRC_PHYS_LAST) begin
            v = phys[4'(code[4:0] - 5'd1)]; // [RL12]
        end else if (code[6:0] >= DIO_SRC_AUX_FIRST && code[6:0] <= DIO_SRC_AUX_LAST) begin
            v = aux[3'(code[2:0] - 3'd1)]; // [RL12]
        end
        return v ^ code[DIO_SRC_INV_BIT]; // [RL13]
    endfunction

    // Direct-mode conditioning: inversion, then forcing.
    assign proc_w = (force_en_r[DIO_NUM_IN-1:0] & force_val_r[DIO_NUM_IN-1:0])
                  | (~force_en_r[DIO_NUM_IN-1:0]
                     & (stable_r[DIO_NUM_IN-1:0] ^ in_inv_r[DIO_NUM_IN-1:0])); // [RL4] [RL5]

    always_comb begin
        direct_w = '0;
        for (int i = 0; i < DIO_NUM_IN; i++) begin
            direct_w[DIO_LVL_BASE + i] = proc_w[i]; // [RL3] [RL7] [RL8]
            if (i <= DIO_BIT_INTERLOCK) begin
                direct_w[i] = proc_w[i] & sf_en_r[i]; // [RL2]
            end
        end
    end

    generate
        for (genvar g = 0; g < 32; g++) begin : g_route
            assign routed_w[g] = route_bit(route_tbl_r[g], 16'(stable_r[DIO_NUM_IN-1:0]),
                                           stable_r[NSRC-1:DIO_NUM_IN]); // [RL11]
        end
    endgenerate

    always_comb begin
        case (mode_r)
            DIO_MODE_DIRECT: summary_nxt = direct_w;
            DIO_MODE_ROUTED: summary_nxt = routed_w; // [RL9]
            default:         summary_nxt = direct_w;
        endcase
    end

    // Input mode: a write of one in direct mode preloads the table and enters routing.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            mode_r <= DIO_MODE_DIRECT;
        end else if (wr_w && addr_w == DIO_OFS_IN_ROUTE) begin
            mode_r <= wd_w[0] ? DIO_MODE_ROUTED : DIO_MODE_DIRECT; // [RL9]
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < 32; i++) begin
                route_tbl_r[i] <= DIO_SRC_ZERO;
            end
        end else if (route_on_w) begin
            for (int i = 0; i < 32; i++) begin
                route_tbl_r[i] <= dflt_code(i, sf_en_r, in_inv_r,
                                            force_en_r, force_val_r); // [RL10]
            end
        end else if (wr_w && addr_w[7]) begin
            route_tbl_r[addr_w[6:2]] <= wd_w[7:0];
        end
    end

    // Software-written configuration.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sf_en_r     <= DIO_RST_WORD;
            in_inv_r    <= DIO_RST_WORD;
            force_en_r  <= DIO_RST_WORD;
            force_val_r <= DIO_RST_WORD;
            out_ctrl_r  <= DIO_RST_WORD;
            out_inv_r   <= DIO_RST_WORD;
            man_en_r    <= DIO_RST_WORD;
            man_val_r   <= DIO_RST_WORD;
            out_route_r <= 1'b0;
            led_r       <= DIO_RST_LED;
        end else if (wr_w) begin
            case (addr_w)
                DIO_OFS_SF_EN:     sf_en_r     <= wd_w;
                DIO_OFS_IN_INV:    in_inv_r    <= wd_w;
                DIO_OFS_FORCE_EN:  force_en_r  <= wd_w;
                DIO_OFS_FORCE_VAL: force_val_r <= wd_w;
                DIO_OFS_OUT_CTRL:  out_ctrl_r  <= wd_w;
                DIO_OFS_OUT_INV:   out_inv_r   <= wd_w;
                DIO_OFS_MAN_EN:    man_en_r    <= wd_w;
                DIO_OFS_MAN_VAL:   man_val_r   <= wd_w;
                DIO_OFS_OUT_ROUTE: out_route_r <= wd_w[0]; // [RL21]
                DIO_OFS_LED:       led_r       <= wd_w[1:0];
                default: ;
            endcase
        end
    end

    // Input capture on the strobe.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            raw_r     <= DIO_RST_WORD;
            summary_r <= DIO_RST_WORD;
        end else if (tick_r) begin
            raw_r     <= 32'(stable_r[DIO_NUM_IN-1:0]); // [RL6]
            summary_r <= summary_nxt; // [RL24]
        end
    end

    // Output processing: brake at bit 0, output n at bit 15+n.
    always_comb begin
        applied_nxt = '0;
        for (int b = 0; b < DIO_LVL_BASE + DIO_NUM_OUT; b++) begin
            if (b == DIO_BIT_BRAKE || b >= DIO_LVL_BASE) begin
                if (out_route_r) begin
                    applied_nxt[b] = out_ctrl_r[b]; // [RL22]
                end else if (man_en_r[b]) begin
                    applied_nxt[b] = man_val_r[b]; // [RL19]
                end else begin
                    applied_nxt[b] = out_ctrl_r[b] ^ out_inv_r[b]; // [RL16] [RL17] [RL18]
                end
            end
        end
    end

    // Open-drain pins pull low when the applied level is low.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            applied_r      <= DIO_RST_WORD;
            brake_out      <= 1'b0;
            out_pin_oe_out <= '1;
            out_pin_out    <= '0;
        end else if (tick_r) begin
            applied_r      <= applied_nxt; // [RL20]
            brake_out      <= applied_nxt[DIO_BIT_BRAKE]; // [RL17]
            out_pin_oe_out <= ~applied_nxt[DIO_LVL_BASE +: DIO_NUM_OUT]; // [RL16]
            out_pin_out    <= '0;
        end
    end

    // Interlock release and LEDs.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            interlock_fault_out <= 1'b0;
            led_green_out       <= 1'b0;
            led_red_out         <= 1'b0;
        end else begin
            interlock_fault_out <= sf_en_r[DIO_BIT_INTERLOCK]
                                   && !summary_r[DIO_BIT_INTERLOCK]; // [RL14] [RL15]
            led_green_out <= led_r[DIO_BIT_GREEN] && blink_r
                             && !interlock_fault_out; // [RL23]
            led_red_out   <= led_r[DIO_BIT_RED] && blink_r
                             && interlock_fault_out; // [RL23]
        end
    end

    // Read port: data stand in the cycle after the strobe only.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !bus_req_in.rd) begin
            bus_rdata_out <= '0;
        end else if (addr_w[7]) begin
            bus_rdata_out <= 32'(route_tbl_r[addr_w[6:2]]);
        end else begin
            case (addr_w)
                DIO_OFS_SF_EN:     bus_rdata_out <= sf_en_r;
                DIO_OFS_IN_INV:    bus_rdata_out <= in_inv_r;
                DIO_OFS_FORCE_EN:  bus_rdata_out <= force_en_r;
                DIO_OFS_FORCE_VAL: bus_rdata_out <= force_val_r;
                DIO_OFS_RAW:       bus_rdata_out <= raw_r;
                DIO_OFS_SUMMARY:   bus_rdata_out <= summary_r;
                DIO_OFS_IN_ROUTE:  bus_rdata_out <= 32'(mode_r == DIO_MODE_ROUTED);
                DIO_OFS_OUT_CTRL:  bus_rdata_out <= out_ctrl_r;
                DIO_OFS_OUT_INV:   bus_rdata_out <= out_inv_r;
                DIO_OFS_MAN_EN:    bus_rdata_out <= man_en_r;
                DIO_OFS_MAN_VAL:   bus_rdata_out <= man_val_r;
                DIO_OFS_APPLIED:   bus_rdata_out <= applied_r;
                DIO_OFS_OUT_ROUTE: bus_rdata_out <= 32'(out_route_r);
                DIO_OFS_LED:       bus_rdata_out <= 32'(led_r);
                default:           bus_rdata_out <= '0;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    AST_TICK_SPACING: assert property ( // [RL1]
        tick_r |-> $past(cnt_r) == CW'(SAMPLE_CYCLES - 1))
        else $error("sampling strobe off its period");

    AST_RAW_CAPTURE: assert property ( // [RL6]
        tick_r |=> raw_r == 32'($past(stable_r[DIO_NUM_IN-1:0])))
        else $error("raw word did not capture the sampled level");

    AST_SUMMARY_HOLD: assert property ( // [RL24]
        !tick_r |=> $stable(summary_r))
        else $error("summary changed without the strobe");

    AST_SF_GATE: assert property ( // [RL3]
        tick_r && mode_r == DIO_MODE_DIRECT && !sf_en_r[0] && !force_en_r[0]
        |=> !summary_r[0] && summary_r[DIO_LVL_BASE] ==
            $past(stable_r[0] ^ in_inv_r[0]))
        else $error("special bit not gated or level bit disturbed");

    AST_FORCE: assert property ( // [RL5]
        tick_r && mode_r == DIO_MODE_DIRECT && force_en_r[DIO_NUM_IN - 1]
        |=> summary_r[DIO_LVL_BASE + DIO_NUM_IN - 1] == $past(force_val_r[DIO_NUM_IN - 1]))
        else $error("forced value not applied");

    AST_PRELOAD: assert property ( // [RL10]
        route_on_w && !force_en_r[0]
        |=> mode_r == DIO_MODE_ROUTED
            && route_tbl_r[DIO_LVL_BASE] == {$past(in_inv_r[0]), 7'h01})
        else $error("routing table not preloaded");

    AST_INTERLOCK: assert property ( // [RL14]
        sf_en_r[DIO_BIT_INTERLOCK] && !summary_r[DIO_BIT_INTERLOCK]
        ##1 sf_en_r[DIO_BIT_INTERLOCK] |-> interlock_fault_out)
        else $error("interlock fault not raised");

    AST_BRAKE: assert property ( // [RL17]
        tick_r && !out_route_r && !man_en_r[0]
        |=> brake_out == $past(out_ctrl_r[0] ^ out_inv_r[0]))
        else $error("brake level wrong");

    AST_MANUAL: assert property ( // [RL19]
        tick_r && !out_route_r && man_en_r[DIO_LVL_BASE + 1]
        |=> out_pin_oe_out[1] == !$past(man_val_r[DIO_LVL_BASE + 1]))
        else $error("manual value not driven");

    AST_APPLIED: assert property ( // [RL20]
        applied_r[DIO_LVL_BASE +: DIO_NUM_OUT] == ~out_pin_oe_out
        && applied_r[DIO_BIT_BRAKE] == brake_out)
        else $error("applied word differs from pins");

    AST_LED_OFF: assert property ( // [RL23]
        !led_r[DIO_BIT_GREEN] |=> !led_green_out)
        else $error("green led on while disabled");

    COV_ROUTED: cover property (route_on_w ##1 mode_r == DIO_MODE_ROUTED);
    COV_FAULT: cover property ($rose(interlock_fault_out));
    COV_MANUAL: cover property (tick_r && man_en_r[DIO_BIT_BRAKE]);

endmodule

//--- tb/dio_pin_model.sv
// Far-side model: switches, sensors and pulled-up open-drain loads.
// Assumes the bench sets switch and sensor levels just after a clock edge.
`timescale 1ns/1ps

module dio_pin_model
    import dio_pkg::*;
(
    // Levels set by the bench.
    input  wire logic [DIO_NUM_IN-1:0]  sw_in,
    input  wire logic [6:0]             aux_in,
    // Open-drain side of the block.
    input  wire logic [DIO_NUM_OUT-1:0] od_pin_in,
    input  wire logic [DIO_NUM_OUT-1:0] od_oe_in,
    // Levels at the block's input pins and at the loads.
    output logic [DIO_NUM_IN-1:0]       in_pin_out,
    output logic [2:0]                  hall_out,
    output logic [2:0]                  enc_out,
    output logic                        usb_out,
    output logic [DIO_NUM_OUT-1:0]      load_lvl_out
);
    // Switches and sensors hold a level far longer than one sample period.
    assign in_pin_out = sw_in;
    assign hall_out   = aux_in[2:0];
    assign enc_out    = aux_in[5:3];
    assign usb_out    = aux_in[6];
    // A released open-drain line is lifted by the load's pull-up.
    assign load_lvl_out = (od_oe_in & od_pin_in) | ~od_oe_in;
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the digital I/O conditioning block.
// Assumes a short sample period so that each update lands within a few dozen cycles.
`timescale 1ns/1ps

module tb_top;
    import dio_pkg::*;
    localparam int SC = 20;
    logic         ref_clk_in = 1'b0;
    logic         reset_in   = 1'b1;
    dio_bus_req_t req        = '0;
    logic [4:0]   sw         = 5'h0;
    logic [6:0]   aux        = 7'h0;
    logic [31:0]  rdata;
    logic [4:0]   pin;
    logic [2:0]   hall;
    logic [2:0]   enc;
    logic         usb;
    logic         brake;
    logic         fault;
    logic         grn;
    logic         red;
    logic [1:0]   od;
    logic [1:0]   oe;
    logic [1:0]   lvl;
    int           num_errors = 0;
    int           n_tests    = 0;

    always #2 ref_clk_in = ~ref_clk_in;

    dio_io_cond #(.SAMPLE_CYCLES(SC), .BLINK_TICKS(2)) dio_io_cond_i (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .bus_req_in(req),
        .bus_rdata_out(rdata), .in_pin_in(pin), .hall_in(hall), .enc_in(enc),
        .usb_pwr_in(usb), .out_pin_out(od), .out_pin_oe_out(oe), .brake_out(brake),
        .interlock_fault_out(fault), .led_green_out(grn), .led_red_out(red));

    dio_pin_model dio_pin_model_i (
        .sw_in(sw), .aux_in(aux), .od_pin_in(od), .od_oe_in(oe), .in_pin_out(pin),
        .hall_out(hall), .enc_out(enc), .usb_out(usb), .load_lvl_out(lvl));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_in);
        req <= '0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_in);
        req <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge ref_clk_in);
        req <= '0;
        #1;
        chk(nm, e, rdata);
    endtask

    // Waits for a few sample strobes, enough for any change to reach the outputs.
    task automatic settle;
        repeat (3 * SC) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic t_reset;
        rchk("led_reg", DIO_OFS_LED, 32'h0000_0003);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        wr(DIO_OFS_RAW, 32'hFFFF_FFFF);
        rchk("raw_ro", DIO_OFS_RAW, 32'h0000_0000);
    endtask

    task automatic t_inputs;
        @(posedge ref_clk_in);
        sw <= 5'h16;
        wr(DIO_OFS_SF_EN, 32'h0000_000F);
        wr(DIO_OFS_IN_INV, 32'h0000_0001);
        wr(DIO_OFS_FORCE_EN, 32'h0000_0010);
        wr(DIO_OFS_FORCE_VAL, 32'h0000_0010);
        settle;
        rchk("raw", DIO_OFS_RAW, 32'h0000_0016);
        rchk("summary", DIO_OFS_SUMMARY, 32'h0017_0007);
        chk("fault", 1, fault);
        wr(DIO_OFS_SF_EN, 32'h0000_0007);
        settle;
        chk("fault_off", 0, fault);
        wr(DIO_OFS_SF_EN, 32'h0000_0000);
        settle;
        rchk("sf_gate", DIO_OFS_SUMMARY, 32'h0017_0000);
        wr(DIO_OFS_SF_EN, 32'h0000_000F);
        settle;
    endtask

    task automatic t_leds;
        int g;
        int r;
        for (int k = 0; k < 2; k++) begin
            g = 0;
            r = 0;
            repeat (8 * SC) begin
                @(posedge ref_clk_in);
                #1;
                g += int'(grn === 1'b1);
                r += int'(red === 1'b1);
            end
            chk("green_on", 0, g);
            chk("red_seen", 32'(1 - k), 32'(r > 0));
            wr(DIO_OFS_LED, 32'(3 * k));
        end
    endtask

    task automatic t_route;
        logic [7:0] codes [8] = '{8'h80, 8'h00, 8'h41, 8'hC7, 8'h44, 8'h06, 8'h85, 8'h47};
        int g;
        wr(DIO_OFS_IN_ROUTE, 32'h0000_0001);
        settle;
        rchk("preload", DIO_OFS_SUMMARY, 32'h0017_0007);
        for (int i = 0; i < 8; i++)
            wr(DIO_OFS_TABLE + 8'(4 * (i < 4 ? i : i + 12)), {24'h0, codes[i]});
        wr(DIO_OFS_IN_INV, 32'h0000_0000);
        wr(DIO_OFS_FORCE_EN, 32'h0000_0000);
        @(posedge ref_clk_in);
        aux <= 7'h49;
        settle;
        rchk("routed", DIO_OFS_SUMMARY, 32'h0019_0005);
        rchk("table", DIO_OFS_TABLE + 8'h0C, 32'h0000_00C7);
        chk("lock_low", 1, fault);
        wr(DIO_OFS_TABLE + 8'h0C, 32'h0000_0080);
        settle;
        chk("lock_high", 0, fault);
        rchk("route_en", DIO_OFS_IN_ROUTE, 32'h0000_0001);
        g = 0;
        repeat (8 * SC) begin
            @(posedge ref_clk_in);
            #1;
            g += int'(grn === 1'b1);
        end
        chk("green_seen", 1, 32'(g > 0));
        wr(DIO_OFS_IN_ROUTE, 32'h0000_0000);
        settle;
        rchk("direct_again", DIO_OFS_SUMMARY, 32'h0016_0006);
    endtask

    task automatic t_outputs;
        wr(DIO_OFS_OUT_CTRL, 32'h0003_0001);
        wr(DIO_OFS_OUT_INV, 32'h0002_0000);
        settle;
        rchk("applied", DIO_OFS_APPLIED, 32'h0001_0001);
        chk("brake", 1, brake);
        chk("loads", 2'b01, lvl);
        wr(DIO_OFS_MAN_EN, 32'h0002_0001);
        wr(DIO_OFS_MAN_VAL, 32'h0002_0000);
        settle;
        chk("man_brake", 0, brake);
        chk("man_loads", 2'b11, lvl);
        wr(DIO_OFS_OUT_UNUSE, 32'hFFFF_FFFF);
        rchk("unused", DIO_OFS_OUT_UNUSE, 32'h0000_0000);
        wr(DIO_OFS_OUT_ROUTE, 32'h0000_0001);
        settle;
        rchk("route_out", DIO_OFS_APPLIED, 32'h0003_0001);
        chk("route_brake", 1, brake);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        t_reset;
        t_inputs;
        t_leds;
        t_route;
        t_outputs;
        final_report;
    end
endmodule
